// ---- src/gbm_master.v ----
// guest bus master: turns mailbox and DMA requests into peripheral bus cycles
// assumes requesters hold req until ack; peripheral pins are asynchronous
`timescale 1ns/10ps
`include "gbm_map.vh"

module gbm_master
(
    input  wire       CORE_CLK,
    input  wire       RST_N,
    // mailbox handshake side
    input  wire       MBX_REQ,
    input  wire       MBX_WRITE,
    input  wire [2:0] MBX_SEL,
    input  wire [2:0] MBX_ADDR,
    input  wire [7:0] MBX_WDATA,
    output wire       MBX_ACK,
    output wire [7:0] MBX_RDATA,
    // streaming dma side
    input  wire       DMA_REQ,
    input  wire       DMA_WRITE,
    input  wire [2:0] DMA_SEL,
    input  wire [2:0] DMA_ADDR,
    input  wire [7:0] DMA_WDATA,
    output wire       DMA_ACK,
    output wire [7:0] DMA_RDATA,
    // peripheral pins
    output wire [7:0] PERIPH_SELECT_N,
    output wire [2:0] PERIPH_ADDR,
    input  wire [7:0] PERIPH_DATA_I,
    output wire [7:0] PERIPH_DATA_O,
    output wire       PERIPH_DATA_OE,
    output wire       PERIPH_READ_N,
    output wire       PERIPH_WRITE_N,
    input  wire       PERIPH_READY,
    input  wire       PERIPH_WAIT_N,
    input  wire [1:0] PERIPH_IRQ,
    output wire [1:0] IRQ_EVENT
);

    // ------------------------------------------------------------------------
    // pin synchronisers: stage 1 feeds stage 2 only
    // ------------------------------------------------------------------------
    reg       rdy_s1_r;
    reg       rdy_s2_r;
    reg       rdy_s3_r;
    reg       wt_s1_r;
    reg       wt_s2_r;
    reg       wt_s3_r;
    reg       rdy_r;
    reg       wt_n_r;
    reg [7:0] dat_s1_r;
    reg [7:0] dat_s2_r;
    reg [7:0] dat_s3_r;
    reg [7:0] dat_r;

    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rdy_s1_r <= 1'b0;
            rdy_s2_r <= 1'b0;
            rdy_s3_r <= 1'b0;
            wt_s1_r  <= 1'b1;
            wt_s2_r  <= 1'b1;
            wt_s3_r  <= 1'b1;
            rdy_r    <= 1'b0;
            wt_n_r   <= 1'b1;
            dat_s1_r <= `GBM_DATA_RST;
            dat_s2_r <= `GBM_DATA_RST;
            dat_s3_r <= `GBM_DATA_RST;
            dat_r    <= `GBM_DATA_RST;
        end
        else
        begin
            rdy_s1_r <= PERIPH_READY;
            rdy_s2_r <= rdy_s1_r;
            rdy_s3_r <= rdy_s2_r;
            wt_s1_r  <= PERIPH_WAIT_N;
            wt_s2_r  <= wt_s1_r;
            wt_s3_r  <= wt_s2_r;
            dat_s1_r <= PERIPH_DATA_I;
            dat_s2_r <= dat_s1_r;
            dat_s3_r <= dat_s2_r;
            if (rdy_s2_r == rdy_s3_r)
                rdy_r <= rdy_s3_r;
            if (wt_s2_r == wt_s3_r)
                wt_n_r <= wt_s3_r;
            // same latency as wait, so data settled with it is caught
            if (dat_s2_r == dat_s3_r)
                dat_r <= dat_s3_r;
        end
    end

    // ------------------------------------------------------------------------
    // cycle state machine
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE   = `GBM_ST_IDLE;
    localparam [2:0] ST_SETUP  = `GBM_ST_SETUP;
    localparam [2:0] ST_STROBE = `GBM_ST_STROBE;
    localparam [2:0] ST_HOLD   = `GBM_ST_HOLD;
    localparam [2:0] ST_DONE   = `GBM_ST_DONE;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg       own_mbx_r;
    reg       wr_r;
    reg [7:0] cs_n_r;
    reg [2:0] addr_r;
    reg [7:0] wdata_r;
    reg       oe_r;
    reg       rd_n_r;
    reg       wr_n_r;
    reg [7:0] mbx_rdata_r;
    reg [7:0] dma_rdata_r;
    reg [2:0] cnt_r;

    // strobe may end once ready is high and wait is released
    wire      periph_go = rdy_r & wt_n_r;
    wire      min_done  = (cnt_r == `GBM_CNT_ZERO);
    // mailbox wins any arbitration so dma never starves host commands
    wire      pick_mbx  = MBX_REQ;
    wire      any_req   = MBX_REQ | DMA_REQ;
    // counter load kept wide, cut to the counter width on purpose
    wire [31:0] strobe_load = `GBM_STROBE_CYC - `GBM_CNT_ONE;

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (any_req)
                    state_nxt = ST_SETUP;
            ST_SETUP:
                state_nxt = ST_STROBE;
            ST_STROBE:
                if (min_done && periph_go)
                    state_nxt = ST_HOLD;
            ST_HOLD:
                state_nxt = ST_DONE;
            ST_DONE:
                state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_r     <= ST_IDLE;
            own_mbx_r   <= 1'b0;
            wr_r        <= 1'b0;
            cs_n_r      <= `GBM_CS_IDLE;
            addr_r      <= `GBM_ADDR_RST;
            wdata_r     <= `GBM_DATA_RST;
            oe_r        <= 1'b0;
            rd_n_r      <= 1'b1;
            wr_n_r      <= 1'b1;
            mbx_rdata_r <= `GBM_DATA_RST;
            dma_rdata_r <= `GBM_DATA_RST;
            cnt_r       <= `GBM_CNT_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            case (state_r)
                ST_IDLE:
                    if (any_req)
                    begin
                        own_mbx_r <= pick_mbx;
                        wr_r      <= pick_mbx ? MBX_WRITE : DMA_WRITE;
                        cs_n_r    <= ~(`GBM_ONE_CS << (pick_mbx ? MBX_SEL : DMA_SEL));
                        addr_r    <= pick_mbx ? MBX_ADDR : DMA_ADDR;
                        wdata_r   <= pick_mbx ? MBX_WDATA : DMA_WDATA;
                        oe_r      <= pick_mbx ? MBX_WRITE : DMA_WRITE;
                    end
                ST_SETUP:
                begin
                    rd_n_r <= wr_r;
                    wr_n_r <= ~wr_r;
                    cnt_r  <= strobe_load[2:0];
                end
                ST_STROBE:
                begin
                    if (!min_done)
                        cnt_r <= cnt_r - `GBM_CNT_ONE;
                    if (min_done && periph_go)
                    begin
                        rd_n_r <= 1'b1;
                        wr_n_r <= 1'b1;
                        if (!wr_r && own_mbx_r)
                            mbx_rdata_r <= dat_r;
                        if (!wr_r && !own_mbx_r)
                            dma_rdata_r <= dat_r;
                    end
                end
                ST_HOLD:
                begin
                    cs_n_r <= `GBM_CS_IDLE;
                    oe_r   <= 1'b0;
                end
                default:
                    cs_n_r <= `GBM_CS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    wire done = (state_r == ST_DONE);

    assign MBX_ACK         = done & own_mbx_r;
    assign DMA_ACK         = done & ~own_mbx_r;
    assign MBX_RDATA       = mbx_rdata_r;
    assign DMA_RDATA       = dma_rdata_r;
    assign PERIPH_SELECT_N = cs_n_r;
    assign PERIPH_ADDR     = addr_r;
    assign PERIPH_DATA_O   = wdata_r;
    assign PERIPH_DATA_OE  = oe_r;
    assign PERIPH_READ_N   = rd_n_r;
    assign PERIPH_WRITE_N  = wr_n_r;

    gbm_irq_edge u_irq
    (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .irq_pin   (PERIPH_IRQ),
        .irq_pulse (IRQ_EVENT)
    );

endmodule

// ---- src/gbm_map.vh ----
// constants for the guest bus master port: state codes, field widths, timing counts
// assumes inclusion by gbm_master.v and gbm_irq_edge.v only
`ifndef GBM_MAP_VH
`define GBM_MAP_VH

// ----------------------------------------------------------------------------
// state machine codes
// ----------------------------------------------------------------------------
`define GBM_ST_IDLE   3'h0
`define GBM_ST_SETUP  3'h1
`define GBM_ST_STROBE 3'h2
`define GBM_ST_HOLD   3'h3
`define GBM_ST_DONE   3'h4

// ----------------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------------
`define GBM_CS_W      4'h8
`define GBM_CS_IDLE   8'hFF
`define GBM_ONE_CS    8'h01
`define GBM_ADDR_RST  3'h0
`define GBM_DATA_RST  8'h00

// ----------------------------------------------------------------------------
// timing: least strobe width in ns, cycles derived at 100 ns clock
// ----------------------------------------------------------------------------
// width must outlast the pin sync, else a wait raised at strobe start is missed
`define GBM_CLK_NS        100
`define GBM_STROBE_MIN_NS 500
`define GBM_STROBE_CYC    ((`GBM_STROBE_MIN_NS + `GBM_CLK_NS - 1) / `GBM_CLK_NS)
`define GBM_CNT_ZERO      3'h0
`define GBM_CNT_ONE       3'h1

`endif

// ---- src/gbm_irq_edge.v ----
// rising-edge detector for the two peripheral interrupt inputs
// assumes inputs are asynchronous pins; three-stage sync with 2nd/3rd agreement
`timescale 1ns/10ps
`include "gbm_map.vh"

module gbm_irq_edge
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire [1:0] irq_pin,
    output wire [1:0] irq_pulse
);

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_irq
            reg s1_r;
            reg s2_r;
            reg s3_r;
            reg lvl_r;
            reg pulse_r;
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_r    <= 1'b0;
                    s2_r    <= 1'b0;
                    s3_r    <= 1'b0;
                    lvl_r   <= 1'b0;
                    pulse_r <= 1'b0;
                end
                else
                begin
                    s1_r    <= irq_pin[i];
                    s2_r    <= s1_r;
                    s3_r    <= s2_r;
                    pulse_r <= 1'b0;
                    // level changes only when stages two and three agree
                    if (s2_r == s3_r)
                    begin
                        lvl_r   <= s3_r;
                        pulse_r <= s3_r & ~lvl_r;
                    end
                end
            end
            assign irq_pulse[i] = pulse_r;
        end
    endgenerate

endmodule

// ---- verification/gbm_chk.sv ----
// pin-level assertions for the guest bus master
// assumes a bind onto gbm_master; one clock domain
`timescale 1ns/10ps
module gbm_chk
(
    input wire       CORE_CLK,
    input wire       RST_N,
    input wire [7:0] PERIPH_SELECT_N,
    input wire [2:0] PERIPH_ADDR,
    input wire       PERIPH_DATA_OE,
    input wire       PERIPH_READ_N,
    input wire       PERIPH_WRITE_N,
    input wire       PERIPH_READY,
    input wire       PERIPH_WAIT_N,
    input wire [1:0] PERIPH_IRQ,
    input wire [1:0] IRQ_EVENT,
    input wire       MBX_ACK,
    input wire       DMA_ACK
);
    wire stb_n = PERIPH_READ_N & PERIPH_WRITE_N;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // six samples: room for the pin sync and its filter
    sequence wait_held;
        (!stb_n && !PERIPH_WAIT_N)[*6];
    endsequence
    sequence rdy_low;
        (!stb_n && !PERIPH_READY)[*6];
    endsequence
    sequence strobe_end;
        $rose(stb_n);
    endsequence
    cs_onehot_a: assert property (PERIPH_SELECT_N == 8'hFF || $onehot(~PERIPH_SELECT_N))
        else $error("chip selects not one-cold");
    addr_stable_a: assert property (!stb_n && !$past(stb_n) |-> $stable(PERIPH_ADDR))
        else $error("address moved under strobe");
    rd_sel_a: assert property (!PERIPH_READ_N |-> PERIPH_SELECT_N != 8'hFF && !PERIPH_DATA_OE)
        else $error("read strobe without select or with drive");
    wr_oe_a: assert property (!PERIPH_WRITE_N |-> PERIPH_DATA_OE && PERIPH_READ_N)
        else $error("write strobe without drive");
    wait_hold_a: assert property (wait_held |=> !stb_n)
        else $error("strobe ended during wait");
    ready_hold_a: assert property (rdy_low |=> !stb_n)
        else $error("strobe ended while not ready");
    ack_after_a: assert property (strobe_end |-> ##[1:3] (MBX_ACK ^ DMA_ACK))
        else $error("no single ack after strobe");
    irq_event_a: assert property ($rose(PERIPH_IRQ[0]) |-> ##[2:6] IRQ_EVENT[0])
        else $error("irq edge not reported");
    irq_single_a: assert property ((IRQ_EVENT & $past(IRQ_EVENT)) == 2'b00)
        else $error("irq event longer than a cycle");
endmodule
bind gbm_master gbm_chk u_gbm_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .PERIPH_SELECT_N(PERIPH_SELECT_N), .PERIPH_ADDR(PERIPH_ADDR),
    .PERIPH_DATA_OE(PERIPH_DATA_OE), .PERIPH_READ_N(PERIPH_READ_N),
    .PERIPH_WRITE_N(PERIPH_WRITE_N), .PERIPH_READY(PERIPH_READY),
    .PERIPH_WAIT_N(PERIPH_WAIT_N), .PERIPH_IRQ(PERIPH_IRQ),
    .IRQ_EVENT(IRQ_EVENT), .MBX_ACK(MBX_ACK), .DMA_ACK(DMA_ACK));

// ---- verification/gbm_periph.sv ----
// behavioural peripheral: 8 devices of 8 byte registers
// assumes strobes and selects come from the master; slow adds wait states
`timescale 1ns/10ps
module gbm_periph
(
    input  wire       clk,
    input  wire [7:0] sel_n,
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    input  wire       oe,
    input  wire       rd_n,
    input  wire       wr_n,
    input  wire       slow,
    output logic [7:0] rdata,
    output logic      ready,
    output logic      wait_n
);
    logic [7:0] mem [0:63];
    logic [7:0] last = 8'h00;
    logic [2:0] idx;
    int         cnt = 0;
    wire        on = !(rd_n & wr_n);
    always @*
    begin
        idx = 3'h0;
        for (int i = 0; i < 8; i++)
            if (!sel_n[i])
                idx = i[2:0];
    end
    assign ready = !(slow && on && cnt < 8);
    assign wait_n = !(slow && on && cnt < 10);
    // no pull on the data lines: released bus shows the inverse
    assign rdata = (!rd_n && sel_n != 8'hFF) ? mem[{idx, addr}] : ~last;
    always @(posedge clk)
    begin
        cnt <= on ? cnt + 1 : 0;
        if (!rd_n)
            last <= rdata;
        if (!wr_n && oe && sel_n != 8'hFF)
            mem[{idx, addr}] <= wdata;
    end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for gbm_master with a peripheral model
// assumes the checker is bound in; inputs change on falling edges
`timescale 1ns/10ps
module tb_top;
    logic       clk, rst_n, m_req, m_wr, d_req, d_wr, slow, oe, rd_n, wr_n, rdy, wt_n;
    logic       m_ack, d_ack;
    logic [2:0] m_sel, m_addr, d_sel, d_addr, adr;
    logic [7:0] m_wd, d_wd, sel_n, d_o, drv, m_rd, d_rd;
    logic [1:0] irq, ev;
    int         err_total, num_checks, n;
    wire  [7:0] pin = oe ? d_o : drv;
    gbm_master u_gbm_master (.CORE_CLK(clk), .RST_N(rst_n), .MBX_REQ(m_req),
        .MBX_WRITE(m_wr), .MBX_SEL(m_sel), .MBX_ADDR(m_addr), .MBX_WDATA(m_wd),
        .MBX_ACK(m_ack), .MBX_RDATA(m_rd), .DMA_REQ(d_req), .DMA_WRITE(d_wr),
        .DMA_SEL(d_sel), .DMA_ADDR(d_addr), .DMA_WDATA(d_wd), .DMA_ACK(d_ack),
        .DMA_RDATA(d_rd), .PERIPH_SELECT_N(sel_n), .PERIPH_ADDR(adr),
        .PERIPH_DATA_I(pin), .PERIPH_DATA_O(d_o), .PERIPH_DATA_OE(oe),
        .PERIPH_READ_N(rd_n), .PERIPH_WRITE_N(wr_n), .PERIPH_READY(rdy),
        .PERIPH_WAIT_N(wt_n), .PERIPH_IRQ(irq), .IRQ_EVENT(ev));
    gbm_periph u_gbm_periph (.clk(clk), .sel_n(sel_n), .addr(adr), .wdata(pin),
        .oe(oe), .rd_n(rd_n), .wr_n(wr_n), .slow(slow), .rdata(drv),
        .ready(rdy), .wait_n(wt_n));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one mailbox cycle; n returns its length in cycles
    task mbx(input logic w, input logic [2:0] s, a, input logic [7:0] wd, exp);
        logic [7:0] cs;
        logic [2:0] ad;
        cs = 8'h00;
        ad = ~a;
        @(negedge clk);
        {m_req, m_wr, m_sel, m_addr, m_wd} = {1'b1, w, s, a, wd};
        n = 0;
        while (!m_ack && n < 300)
        begin
            @(negedge clk);
            n++;
            if (!(w ? wr_n : rd_n))
                {cs, ad} = {sel_n, adr};
        end
        m_req = 1'b0;
        chk({7'h00, m_ack}, 8'h01);
        chk(cs, ~(8'h01 << s));
        chk({5'h00, ad}, {5'h00, a});
        if (!w)
            chk(m_rd, exp);
    endtask
    task t_sweep;
        for (int i = 0; i < 8; i++)
        begin
            mbx(1'b1, i[2:0], i[2:0], 8'hA5 ^ i[7:0], 8'h00);
            mbx(1'b0, i[2:0], i[2:0], 8'h00, 8'hA5 ^ i[7:0]);
        end
    endtask
    task t_slow;
        slow = 1'b1;
        // wait outlasts ready in the model: only honouring wait gets past 16
        mbx(1'b1, 3'h7, 3'h3, 8'h3C, 8'h00);
        chk({7'h00, n > 16}, 8'h01);
        mbx(1'b0, 3'h7, 3'h3, 8'h00, 8'h3C);
        chk({7'h00, n > 16}, 8'h01);
        slow = 1'b0;
    endtask
    task t_prio;
        @(negedge clk);
        {d_req, d_wr, d_sel, d_addr} = {1'b1, 1'b0, 3'h1, 3'h1};
        {m_req, m_wr, m_sel, m_addr, m_wd} = {1'b1, 1'b1, 3'h5, 3'h2, 8'h96};
        n = 0;
        while (!m_ack && !d_ack && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk({6'h00, m_ack, d_ack}, 8'h02);
        m_req = 1'b0;
        while (!d_ack && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        d_req = 1'b0;
        chk(d_rd, 8'hA4);
        mbx(1'b0, 3'h5, 3'h2, 8'h00, 8'h96);
    endtask
    // dma write then read back on its own
    task t_dma;
        for (int k = 0; k < 2; k++)
        begin
            @(negedge clk);
            {d_req, d_wr, d_sel, d_addr, d_wd} = {1'b1, k == 0, 3'h3, 3'h6, 8'h5A};
            n = 0;
            while (!d_ack && n < 300)
            begin
                @(negedge clk);
                n++;
            end
            d_req = 1'b0;
            chk({7'h00, d_ack}, 8'h01);
        end
        chk(d_rd, 8'h5A);
    endtask
    task t_irq(input int i);
        for (int k = 0; k < 3; k++)
        begin
            irq[i] = (k == 0);
            n = 0;
            repeat (12) @(negedge clk) n += ev[i];
            chk(n[7:0], (k == 0) ? 8'h01 : 8'h00);
        end
    endtask
    initial
    begin
        #(100 * 20000);
        err_total++;
        results;
    end
    initial
    begin
        {rst_n, m_req, m_wr, m_sel, m_addr, m_wd, d_req, d_wr, d_sel, d_addr} = '0;
        {d_wd, slow, irq, err_total, num_checks} = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        // ready sync leaves reset low
        repeat (6) @(negedge clk);
        t_sweep;
        t_slow;
        t_prio;
        t_dma;
        t_irq(0);
        t_irq(1);
        results;
    end
endmodule
